// >>> design/pllsd_pkg.sv
// Shared constants of the synthesizer digital core: addresses, fields, reset
// values and timing figures. Assumes a 100 MHz core clock.
package pllsd_pkg;
    // Data-memory addresses of the transfer buffer, mode and unlock registers.
    localparam logic [6:0] ADDR_TBUF3  = 7'h0c;
    localparam logic [6:0] ADDR_TBUF2  = 7'h0d;
    localparam logic [6:0] ADDR_TBUF1  = 7'h0e;
    localparam logic [6:0] ADDR_TBUF0  = 7'h0f;
    localparam logic [6:0] ADDR_MODE   = 7'h6b;
    localparam logic [6:0] ADDR_UNLOCK = 7'h6d;
    // Peripheral address of the divider ratio register.
    localparam logic [6:0] ADDR_RATIO  = 7'h41;
    // Mode register fields and reset values of the mode, ratio and buffer registers.
    localparam int unsigned REF_SEL_LSB  = 0;
    localparam int unsigned DIV_MODE_LSB = 2;
    localparam logic [3:0]  MODE_RESET   = 4'h0;
    localparam logic [15:0] RATIO_RESET  = 16'h0000;
    localparam logic [3:0]  TBUF_RESET   = 4'h0;
    // Division mode codes.
    localparam logic [1:0] DIV_OFF = 2'h0;
    localparam logic [1:0] DIV_MF  = 2'h1;
    localparam logic [1:0] DIV_VHF = 2'h2;
    localparam logic [1:0] DIV_HF  = 2'h3;
    // Reference select codes.
    localparam logic [1:0] REF_1K  = 2'h0;
    localparam logic [1:0] REF_3K  = 2'h1;
    localparam logic [1:0] REF_5K  = 2'h2;
    localparam logic [1:0] REF_25K = 2'h3;
    // Clock rate and reference frequencies; periods in cycles follow.
    localparam int unsigned CLK_HZ     = 100000000;
    localparam int unsigned REF_HZ_1K  = 1000;
    localparam int unsigned REF_HZ_3K  = 3000;
    localparam int unsigned REF_HZ_5K  = 5000;
    localparam int unsigned REF_HZ_25K = 25000;
    localparam int unsigned REF_CYC_1K  = CLK_HZ / REF_HZ_1K;
    localparam int unsigned REF_CYC_3K  = CLK_HZ / REF_HZ_3K;
    localparam int unsigned REF_CYC_5K  = CLK_HZ / REF_HZ_5K;
    localparam int unsigned REF_CYC_25K = CLK_HZ / REF_HZ_25K;
    localparam int unsigned REF_CNT_W   = 17;
    // Two-modulus prescaler base modulus (16 and 17).
    localparam logic [4:0] PRESC_MOD = 5'h10;
    // Phase comparator states.
    typedef enum logic [2:0] {
        PFD_IDLE = 3'b001,
        PFD_UP   = 3'b010,
        PFD_DN   = 3'b100
    } pllsd_pfd_t;
endpackage

// >>> design/pllsd_ref_gen.sv
// Reference frequency generator: divides the core clock to one tick per
// reference period. Assumes select and enable come from the same clock.
`timescale 1ns/100ps
`default_nettype none
module pllsd_ref_gen
    import pllsd_pkg::*;
#(
    parameter int unsigned CYC_1K  = REF_CYC_1K,
    parameter int unsigned CYC_3K  = REF_CYC_3K,
    parameter int unsigned CYC_5K  = REF_CYC_5K,
    parameter int unsigned CYC_25K = REF_CYC_25K
) (
    input  wire logic       core_clk, // Core clock.
    input  wire logic       arst_n,   // Asynchronous reset, active low.
    input  wire logic       enable,   // Generator runs while high.
    input  wire logic [1:0] ref_sel,  // Reference select code.
    output var  logic       ref_tick  // One-cycle pulse per period.
);
    logic [REF_CNT_W-1:0] cnt_reg;
    logic [REF_CNT_W-1:0] last;

    // Terminal count for the selected reference.
    always_comb begin
        case (ref_sel)
            REF_1K:  last = REF_CNT_W'(CYC_1K - 1);
            REF_3K:  last = REF_CNT_W'(CYC_3K - 1);
            REF_5K:  last = REF_CNT_W'(CYC_5K - 1);
            default: last = REF_CNT_W'(CYC_25K - 1);
        endcase
    end

    // The >= compare keeps a shortened period safe after a select change.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg  <= '0;
            ref_tick <= 1'b0;
        end else if (!enable) begin
            cnt_reg  <= '0;
            ref_tick <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg  <= '0;
            ref_tick <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 1'b1;
            ref_tick <= 1'b0;
        end
    end

    AST_REF_STOP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !enable |=> !ref_tick) else $error("Reference tick while stopped.");
endmodule
`default_nettype wire

// >>> design/pllsd_prog_div.sv
// Programmable divider: 4-bit swallow and 12-bit programmable down-counters
// behind a 16/17 prescaler. Assumes vco_edge is a synchronised one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module pllsd_prog_div
    import pllsd_pkg::*;
(
    input  wire logic        core_clk, // Core clock.
    input  wire logic        arst_n,   // Asynchronous reset, active low.
    input  wire logic        enable,   // Division runs while high.
    input  wire logic        swallow,  // High for pulse swallow.
    input  wire logic [15:0] ratio,    // Division ratio N.
    input  wire logic        vco_edge, // One input cycle.
    output var  logic        fn_tick   // One pulse per N input cycles with swallow; per ratio[15:4] cycles when direct.
);
    logic [4:0]  presc_reg;
    logic [3:0]  swal_reg;
    logic [11:0] prog_reg;
    logic [4:0]  modulus;

    // The prescaler divides by 17 while swallow counts remain, else by 16.
    assign modulus = (swal_reg != 4'h0) ? PRESC_MOD + 5'h01 : PRESC_MOD;

    // While disabled the counters hold loaded and division stops.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_reg <= '0;
            swal_reg  <= '0;
            prog_reg  <= '0;
            fn_tick   <= 1'b0;
        end else if (!enable) begin
            presc_reg <= '0;
            swal_reg  <= swallow ? ratio[3:0] : 4'h0;
            prog_reg  <= ratio[15:4];
            fn_tick   <= 1'b0;
        end else if (!vco_edge) begin
            fn_tick <= 1'b0;
        end else if (!swallow) begin
            // Direct: the programmable counter alone, low nibble ignored.
            presc_reg <= '0;
            swal_reg  <= 4'h0;
            if (prog_reg <= 12'h001) begin
                prog_reg <= ratio[15:4];
                fn_tick  <= 1'b1;
            end else begin
                prog_reg <= prog_reg - 12'h001;
                fn_tick  <= 1'b0;
            end
        end else if (presc_reg == modulus - 5'h01) begin
            // N = 16*M + A, since the first A prescaler cycles are 17 long.
            presc_reg <= '0;
            if (prog_reg <= 12'h001) begin
                prog_reg <= ratio[15:4];
                swal_reg <= ratio[3:0];
                fn_tick  <= 1'b1;
            end else begin
                prog_reg <= prog_reg - 12'h001;
                swal_reg <= (swal_reg != 4'h0) ? swal_reg - 4'h1 : 4'h0;
                fn_tick  <= 1'b0;
            end
        end else begin
            presc_reg <= presc_reg + 5'h01;
            fn_tick   <= 1'b0;
        end
    end

    AST_DIV_STOP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !enable |=> !fn_tick) else $error("Divider output while stopped.");
endmodule
`default_nettype wire

// >>> design/pllsd_core.sv
// Digital core of the synthesizer: registers, input selection, phase
// comparator, charge pump control and unlock detection. Assumes the CPU
// data-memory strobes and the put/get strobes are on core_clk; pins are not.
`timescale 1ns/100ps
`default_nettype none

module pllsd_core
    import pllsd_pkg::*;
#(
    parameter int unsigned CYC_1K  = REF_CYC_1K,
    parameter int unsigned CYC_3K  = REF_CYC_3K,
    parameter int unsigned CYC_5K  = REF_CYC_5K,
    parameter int unsigned CYC_25K = REF_CYC_25K
) (
    input  wire logic       core_clk,       // Core clock, 100 MHz.
    input  wire logic       arst_n,         // Power-on reset, active low.
    input  wire logic       ce_pin,         // Chip-enable pin.
    input  wire logic [6:0] mem_addr,       // Data-memory address.
    input  wire logic       mem_we,         // Data-memory write strobe.
    input  wire logic [3:0] mem_wdata,      // Data-memory write nibble.
    input  wire logic       mem_re,         // Data-memory read strobe.
    output var  logic [3:0] mem_rdata,      // Read nibble, next cycle.
    input  wire logic [6:0] periph_addr,    // Peripheral address of put/get.
    input  wire logic       put_req,        // Buffer to peripheral.
    input  wire logic       get_req,        // Peripheral to buffer.
    input  wire logic       vco_low_pin,    // Low-band VCO input.
    input  wire logic       vco_high_pin,   // High-band VCO input.
    output var  logic       vco_low_en,     // Low-band amplifier on; low floats.
    output var  logic       vco_high_en,    // High-band amplifier on; low floats.
    output var  logic       error_out,      // Error output pin level.
    output var  logic       error_oe_n,     // Error output drive, active low.
    output var  logic       up_req_n,       // Up request, active low.
    output var  logic       down_request_n, // Down request, active low.
    output var  logic       synth_disabled  // Synthesizer disabled.
);
    logic [3:0]  mode_reg;
    logic [15:0] ratio_reg;
    logic [3:0]  tbuf_reg [4];
    logic        unlock_reg;
    logic        seen_reg;
    logic [1:0]  ce_sync_reg;
    logic [1:0]  vlo_sync_reg;
    logic [1:0]  vhi_sync_reg;
    logic        vlo_prev_reg;
    logic        vhi_prev_reg;
    logic        vco_edge;
    logic        dis_next;
    logic        ref_tick;
    logic        fn_tick;
    logic        unlock_set;
    logic        unlock_rd;
    logic [1:0]  div_mode;
    pllsd_pfd_t  pfd_reg;
    pllsd_pfd_t  pfd_next;

    // True for either pulse swallow code.
    function automatic logic is_swallow(input logic [1:0] m);
        return (m == DIV_VHF) || (m == DIV_HF);
    endfunction

    // Buffer index of a data-memory address.
    function automatic logic [1:0] tbuf_index(input logic [6:0] a);
        return 2'(ADDR_TBUF0 - a);
    endfunction

    // True for any transfer buffer address.
    function automatic logic is_tbuf(input logic [6:0] a);
        return (a >= ADDR_TBUF3) && (a <= ADDR_TBUF0);
    endfunction

    assign div_mode = mode_reg[DIV_MODE_LSB +: 2];

    // Pins cross two flip-flops before use; the edge logic compares stage two with a one-cycle-delayed copy.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ce_sync_reg  <= 2'h0;
            vlo_sync_reg <= 2'h0;
            vhi_sync_reg <= 2'h0;
            vlo_prev_reg <= 1'b0;
            vhi_prev_reg <= 1'b0;
        end else begin
            ce_sync_reg  <= {ce_sync_reg[0], ce_pin};
            vlo_sync_reg <= {vlo_sync_reg[0], vco_low_pin};
            vhi_sync_reg <= {vhi_sync_reg[0], vco_high_pin};
            vlo_prev_reg <= vlo_sync_reg[1];
            vhi_prev_reg <= vhi_sync_reg[1];
        end
    end

    // Rising edge of the pin that the mode selects; VHF alone uses high-band.
    always_comb begin
        if (div_mode == DIV_VHF) begin
            vco_edge = vhi_sync_reg[1] & ~vhi_prev_reg;
        end else begin
            vco_edge = vlo_sync_reg[1] & ~vlo_prev_reg;
        end
    end

    // Disabled while chip-enable is low or the division field is zero.
    assign dis_next = !ce_sync_reg[1] || (div_mode == DIV_OFF);

    // Mode register; power-on clears it, chip-enable low leaves it alone.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= MODE_RESET;
        end else if (mem_we && mem_addr == ADDR_MODE) begin
            mode_reg <= mem_wdata;
        end
    end

    // Ratio register, written only by a put naming its peripheral address.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ratio_reg <= RATIO_RESET;
        end else if (put_req && periph_addr == ADDR_RATIO) begin
            ratio_reg <= {tbuf_reg[3], tbuf_reg[2], tbuf_reg[1], tbuf_reg[0]};
        end
    end

    // Transfer buffer; a get overrides a plain write in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                tbuf_reg[i] <= TBUF_RESET;
            end
        end else if (get_req && periph_addr == ADDR_RATIO) begin
            tbuf_reg[3] <= ratio_reg[15:12];
            tbuf_reg[2] <= ratio_reg[11:8];
            tbuf_reg[1] <= ratio_reg[7:4];
            tbuf_reg[0] <= ratio_reg[3:0];
        end else if (mem_we && is_tbuf(mem_addr)) begin
            tbuf_reg[tbuf_index(mem_addr)] <= mem_wdata;
        end
    end

    // Read data is registered; unmapped addresses read as zero.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_rdata <= 4'h0;
        end else if (!mem_re) begin
            mem_rdata <= 4'h0;
        end else if (is_tbuf(mem_addr)) begin
            mem_rdata <= tbuf_reg[tbuf_index(mem_addr)];
        end else if (mem_addr == ADDR_MODE) begin
            mem_rdata <= mode_reg;
        end else if (mem_addr == ADDR_UNLOCK) begin
            mem_rdata <= {3'h0, unlock_reg};
        end else begin
            mem_rdata <= 4'h0;
        end
    end

    pllsd_ref_gen #(
        .CYC_1K  (CYC_1K),
        .CYC_3K  (CYC_3K),
        .CYC_5K  (CYC_5K),
        .CYC_25K (CYC_25K)
    ) u_ref_gen (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .enable   (!synth_disabled),
        .ref_sel  (mode_reg[REF_SEL_LSB +: 2]),
        .ref_tick (ref_tick)
    );

    pllsd_prog_div u_prog_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .enable   (!synth_disabled),
        .swallow  (is_swallow(div_mode)),
        .ratio    (ratio_reg),
        .vco_edge (vco_edge),
        .fn_tick  (fn_tick)
    );

    // Phase-frequency comparator: the earlier edge opens a request, the other
    // edge closes it. A lower divided frequency keeps the up request open.
    always_comb begin
        pfd_next = pfd_reg;
        case (pfd_reg)
            PFD_IDLE: begin
                if (ref_tick && !fn_tick) begin
                    pfd_next = PFD_UP;
                end else if (fn_tick && !ref_tick) begin
                    pfd_next = PFD_DN;
                end
            end
            PFD_UP: begin
                if (fn_tick && !ref_tick) begin
                    pfd_next = PFD_IDLE;
                end
            end
            PFD_DN: begin
                if (ref_tick && !fn_tick) begin
                    pfd_next = PFD_IDLE;
                end
            end
            default: pfd_next = PFD_IDLE;
        endcase
        if (dis_next) begin
            pfd_next = PFD_IDLE;
        end
    end

    // Comparator state and every pin-facing output follow from one cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pfd_reg        <= PFD_IDLE;
            synth_disabled <= 1'b1;
            vco_low_en     <= 1'b0;
            vco_high_en    <= 1'b0;
            up_req_n       <= 1'b1;
            down_request_n <= 1'b1;
            error_out      <= 1'b0;
            error_oe_n     <= 1'b1;
        end else begin
            pfd_reg        <= pfd_next;
            synth_disabled <= dis_next;
            vco_low_en     <= !dis_next && div_mode != DIV_VHF;
            vco_high_en    <= !dis_next && div_mode == DIV_VHF;
            up_req_n       <= pfd_next != PFD_UP;
            down_request_n <= pfd_next != PFD_DN;
            error_out      <= pfd_next == PFD_DN;
            error_oe_n     <= pfd_next == PFD_IDLE;
        end
    end

    // Any request within a reference period marks it unlocked; the flag is
    // only set on the reference tick, which paces software reads.
    assign unlock_set = ref_tick && (seen_reg || pfd_reg != PFD_IDLE);
    assign unlock_rd  = mem_re && mem_addr == ADDR_UNLOCK;

    // A set in the cycle of a read wins, so no unlocked period is lost.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_reg   <= 1'b0;
            unlock_reg <= 1'b0;
        end else begin
            if (ref_tick || synth_disabled) begin
                seen_reg <= 1'b0;
            end else if (pfd_reg != PFD_IDLE) begin
                seen_reg <= 1'b1;
            end
            if (unlock_set) begin
                unlock_reg <= 1'b1;
            end else if (unlock_rd) begin
                unlock_reg <= 1'b0;
            end
        end
    end

    AST_DIS_FLOAT: assert property (@(posedge core_clk) disable iff (!arst_n)
        synth_disabled |-> !vco_low_en && !vco_high_en && error_oe_n)
        else $error("Disabled synthesizer drives a pin.");

    AST_NO_REQ: assert property (@(posedge core_clk) disable iff (!arst_n)
        synth_disabled |-> up_req_n && down_request_n)
        else $error("Request while disabled.");

    AST_CE_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
        !ce_sync_reg[1] |=> synth_disabled)
        else $error("Chip-enable low did not disable.");

    AST_MODE_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
        div_mode == DIV_OFF |=> synth_disabled)
        else $error("Zero mode did not disable.");

    AST_VHF_PIN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce_sync_reg[1] && div_mode == DIV_VHF) |=> vco_high_en && !vco_low_en)
        else $error("VHF input selection wrong.");

    AST_MF_PIN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce_sync_reg[1] && div_mode == DIV_MF) |=> vco_low_en && !vco_high_en)
        else $error("Direct input selection wrong.");

    AST_EO_UP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !up_req_n |-> !error_oe_n && !error_out && down_request_n)
        else $error("Error output wrong for up request.");

    AST_MODE_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(mem_we && mem_addr == ADDR_MODE) |=> $stable(mode_reg))
        else $error("Mode register changed without a write.");

    AST_PUT: assert property (@(posedge core_clk) disable iff (!arst_n)
        (put_req && periph_addr == ADDR_RATIO)
        |=> ratio_reg == {$past(tbuf_reg[3]), $past(tbuf_reg[2]),
                          $past(tbuf_reg[1]), $past(tbuf_reg[0])})
        else $error("Put did not load the ratio.");

    AST_UL_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
        (unlock_rd && !unlock_set)
        |=> !unlock_reg && mem_rdata == {3'h0, $past(unlock_reg)})
        else $error("Unlock read-and-clear wrong.");

    AST_UL_SET: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ref_tick && pfd_reg != PFD_IDLE) |=> unlock_reg)
        else $error("Unlock flag not set.");
endmodule
`default_nettype wire

// >>> verif/pllsd_vco_model.sv
// Behavioural VCO pair that feeds the two band inputs of the synthesizer core.
// Assumes half periods in ns of at least 20; a zero stops that oscillator.
`timescale 1ns/100ps
`default_nettype none
module pllsd_vco_model (
    input  var int   half_low,  // Low-band half period, 0 stops it.
    input  var int   half_high, // High-band half period, 0 stops it.
    output var logic vco_low,   // Low-band square wave.
    output var logic vco_high   // High-band square wave.
);
    // A stopped oscillator parks low, so a wrongly chosen pin yields no edges.
    initial begin
        vco_low = 1'b0;
        forever begin
            if (half_low > 0) #(half_low) vco_low = ~vco_low;
            else #10 vco_low = 1'b0;
        end
    end
    initial begin
        vco_high = 1'b0;
        forever begin
            if (half_high > 0) #(half_high) vco_high = ~vco_high;
            else #10 vco_high = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/pllsd_core_test.sv
// Self-checking bench of the synthesizer core: registers, pins, comparator.
// Assumes the VCO model and shortened reference periods of 400, 300, 200 and 2000.
`timescale 1ns/100ps
`default_nettype none
module pllsd_core_test
    import pllsd_pkg::*;
;
    logic       core_clk, arst_n, ce_pin, mem_we, mem_re, put_req, get_req;
    logic [6:0] mem_addr, periph_addr;
    logic [3:0] mem_wdata, mem_rdata;
    logic       vco_low_pin, vco_high_pin, vco_low_en, vco_high_en;
    logic       error_out, error_oe_n, up_req_n, down_request_n, synth_disabled;
    int         half_low, half_high, fails, n_compared;
    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    pllsd_core #(.CYC_1K(400), .CYC_3K(300), .CYC_5K(200), .CYC_25K(2000)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .ce_pin(ce_pin), .mem_addr(mem_addr),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .periph_addr(periph_addr), .put_req(put_req), .get_req(get_req),
        .vco_low_pin(vco_low_pin), .vco_high_pin(vco_high_pin), .vco_low_en(vco_low_en),
        .vco_high_en(vco_high_en), .error_out(error_out), .error_oe_n(error_oe_n),
        .up_req_n(up_req_n), .down_request_n(down_request_n),
        .synth_disabled(synth_disabled));
    pllsd_vco_model vco (.half_low(half_low), .half_high(half_high),
        .vco_low(vco_low_pin), .vco_high(vco_high_pin));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Each bus task opens with an edge so back-to-back strobes never collide.
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        tick(1);
        mem_addr = a;
        mem_wdata = d;
        mem_we = 1'b1;
        tick(1);
        mem_we = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [3:0] e, input string nm);
        tick(1);
        mem_addr = a;
        mem_re = 1'b1;
        tick(1);
        mem_re = 1'b0;
        chk(nm, {12'h000, e}, {12'h000, mem_rdata});
    endtask
    task automatic xfer(input logic p);
        tick(1);
        periph_addr = ADDR_RATIO;
        put_req = p;
        get_req = !p;
        tick(1);
        put_req = 1'b0;
        get_req = 1'b0;
    endtask
    // Ratios below 16 direct or 256 swallow are never programmed.
    task automatic setn(input logic [15:0] n);
        for (int i = 0; i < 4; i++) wr(ADDR_TBUF3 + 7'(i), n[15-4*i -: 4]);
        xfer(1'b1);
    endtask
    task automatic pins(input logic l, input logic h, input logic dis);
        chk("enables", {13'h0, l, h, dis}, {13'h0, vco_low_en, vco_high_en, synth_disabled});
    endtask
    // Long enough to settle, then the driven error level must lean one way;
    // the error pin must also follow the two requests in every cycle.
    task automatic dir(input logic e_down);
        int up = 0;
        int dn = 0;
        int bad = 0;
        tick(1500);
        repeat (3000) begin
            tick(1);
            if (error_oe_n === 1'b0 && error_out === 1'b1) dn++;
            if (error_oe_n === 1'b0 && error_out === 1'b0) up++;
            if (error_oe_n !== (up_req_n & down_request_n)) bad++;
            if (error_oe_n === 1'b0 && error_out !== up_req_n) bad++;
        end
        chk("direction", {15'h0, e_down}, {15'h0, dn > up});
        chk("error pin", 16'h0000, 16'(bad));
    endtask
    task automatic t_idle;
        chk("idle pins", 16'h0007, {13'h0, error_oe_n, up_req_n, down_request_n});
    endtask
    task automatic t_regs;
        wr(ADDR_MODE, 4'h9);
        rd(ADDR_MODE, 4'h9, "mode");
        rd(7'h10, 4'h0, "unmapped");
        wr(ADDR_UNLOCK, 4'hf);
        rd(ADDR_UNLOCK, 4'h0, "unlock");
        setn(16'ha5c3);
        for (int i = 0; i < 4; i++) wr(ADDR_TBUF3 + 7'(i), 4'h0);
        xfer(1'b0);
        for (int i = 0; i < 4; i++) rd(ADDR_TBUF3 + 7'(i), 4'(16'ha5c3 >> (12 - 4*i)), "buf");
    endtask
    task automatic t_mf;
        half_low = 25;
        half_high = 0;
        setn(16'h0107);
        wr(ADDR_MODE, 4'h4);
        tick(5);
        pins(1'b1, 1'b0, 1'b0);
        dir(1'b1);
        setn(16'h0ff5);
        wr(ADDR_MODE, 4'h6);
        dir(1'b0);
        // Stopping the loop first keeps a new set out of the read pair.
        wr(ADDR_MODE, 4'h0);
        tick(5);
        rd(ADDR_UNLOCK, 4'h1, "unlock");
        rd(ADDR_UNLOCK, 4'h0, "unlock");
    endtask
    task automatic t_swallow(input logic vhf);
        half_low = vhf ? 0 : 25;
        half_high = vhf ? 25 : 0;
        setn(16'h0100);
        wr(ADDR_MODE, vhf ? 4'hb : 4'hf);
        tick(5);
        pins(!vhf, vhf, 1'b0);
        dir(1'b1);
        rd(ADDR_UNLOCK, 4'h1, "unlock");
        tick(2100);
        rd(ADDR_UNLOCK, 4'h1, "unlock again");
    endtask
    task automatic t_off;
        wr(ADDR_MODE, 4'h3);
        tick(5);
        pins(1'b0, 1'b0, 1'b1);
        t_idle();
        wr(ADDR_MODE, 4'hb);
        ce_pin = 1'b0;
        tick(5);
        pins(1'b0, 1'b0, 1'b1);
        t_idle();
        rd(ADDR_MODE, 4'hb, "mode");
        ce_pin = 1'b1;
        tick(5);
        pins(1'b0, 1'b1, 1'b0);
    endtask
    task automatic stop_test;
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence: reset for 20 cycles, then each scenario in turn.
    initial begin
        {arst_n, ce_pin, mem_we, mem_re, put_req, get_req} = 6'h00;
        {mem_addr, periph_addr, mem_wdata} = 18'h00000;
        {half_low, half_high, fails, n_compared} = {4{32'h0}};
        tick(20);
        arst_n = 1'b1;
        ce_pin = 1'b1;
        tick(1);
        pins(1'b0, 1'b0, 1'b1);
        t_idle();
        t_regs();
        t_mf();
        t_swallow(1'b0);
        t_swallow(1'b1);
        t_off();
        stop_test();
    end
endmodule
`default_nettype wire
